//--- hw/usb_token_status_defs.vh
// Register map, field layout and timing constants of the token status block
`ifndef USB_TOKEN_STATUS_DEFS_VH
`define USB_TOKEN_STATUS_DEFS_VH
`define ADDR_W 8
`define OFF_SOF 8'h28
`define OFF_PID 8'h2C
`define OFF_EP 8'h30
`define OFF_EPMATCH 8'h34
`define OFF_OTGMASK 8'h38
`define OFF_PWRSIG 8'h3C
`define OFF_XCVR 8'h40
`define OFF_DEVADDR 8'h08
`define PID_TOKEN_OUT 4'h1
`define PID_TOKEN_IN 4'h9
`define PID_TOKEN_SETUP 4'hD
`define PID_TOKEN_SOF 4'h5
`define SPECIAL_EP_FLAG 5'h10
`define XCVR_PDDIS_BIT 18
`define XCVR_SE0CAUSE_BIT 13
`define XCVR_KCAUSE_BIT 12
`define XCVR_FILT_HI 11
`define XCVR_FILT_LO 8
`define XCVR_SUSP_BIT 7
`define XCVR_CONF_HI 6
`define XCVR_CONF_LO 4
`define PWR_VALID_BIT 8
`define LS_SE0 2'h0
`define LS_K 2'h2
`define FILT_CNT_W 16
`define SOF_HI 10
`define PID_HI 3
`define EP_VALID_BIT 4
`define EPM_HI 15
`define PWR_DATA_HI 7
`define DEVADDR_HI 6
`endif

//--- hw/linestate_filter.v
// Line-state change filter with programmable log-2 delay
`timescale 1ns/1ps
module linestate_filter
#(
   parameter CNT_W = 16
)
(
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // Raw synchronised line state and delay setting
   input wire [1:0] lineRaw,
   input wire [3:0] log2Delay,
   // Filtered line state
   output reg [1:0] lineFilt
);
   reg [1:0] pending_r;
   reg [CNT_W-1:0] count_r;
   wire [CNT_W-1:0] target;

   // Delays beyond the counter width saturate at its full count
   assign target = (log2Delay >= CNT_W) ? {CNT_W{1'b1}} :
      ({{(CNT_W-1){1'b0}}, 1'b1} << log2Delay);

   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pending_r <= 2'h0;
         count_r <= {CNT_W{1'b0}};
         lineFilt <= 2'h0;
      end
      else if (lineRaw != pending_r)
      begin
         pending_r <= lineRaw;
         count_r <= {{(CNT_W-1){1'b0}}, 1'b1};
      end
      else if (pending_r != lineFilt)
      begin
         if (count_r >= target)
            lineFilt <= pending_r; // [RL12]
         else
            count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule // linestate_filter

//--- hw/usb_token_status.v
// Token status, endpoint match and transceiver control registers over APB
//
// Behaviour
// [RL1] 11-bit frame counter, split fields, reset zero
// [RL2] Capture last received packet identifier
// [RL3] Keep last token endpoint number
// [RL4] Endpoint-valid flag set by captured token
// [RL5] 16-bit per-endpoint match mask
// [RL6] Matched endpoint delivered ORed with 0x10
// [RL7] 32-bit read-write flag mask register
// [RL8] Power signalling data and valid bits
// [RL9] Pulldown-disable bit turns off port pulldowns
// [RL10] SE0 auto-resume sets reset-cause flag
// [RL11] K auto-resume sets resume-cause flag
// [RL12] Line-state change delayed 2^filter cycles
// [RL13] Suspend controller resumes, else software polls
// [RL14] Config field drives transceiver config pins
// [RL15] Accept only packets for programmed address
// [RL16] Capture fields only on accepted tokens
// [RL17] Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "usb_token_status_defs.vh"
module usb_token_status
#(
   parameter FILT_W = `FILT_CNT_W
)
(
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Decoded token from the packet decoder
   input wire tokValid,
   input wire [3:0] tokPid,
   input wire [6:0] tokAddr,
   input wire [3:0] tokEndp,
   input wire tokCheckOk,
   // Transceiver line state, from pins
   input wire [1:0] lineState,
   input wire suspended,
   // Receive port delivery
   output reg [4:0] rxEndp,
   output reg rxEndpStrobe,
   // Transceiver and port control
   output reg [2:0] xcvrConf,
   output reg pulldownEn,
   output reg resumeReq,
   output reg [1:0] lineFiltOut,
   output reg [7:0] pwrData,
   output reg pwrValid
);
   reg [10:0] sof_r;
   reg [3:0] pid_r;
   reg [3:0] endp_r;
   reg endpValid_r;
   reg [15:0] epMatch_r;
   reg [31:0] otgMask_r;
   reg [7:0] pwrData_r;
   reg pwrValid_r;
   reg pdDis_r;
   reg se0Cause_r;
   reg kCause_r;
   reg [3:0] filt_r;
   reg suspCtl_r;
   reg [2:0] conf_r;
   reg [6:0] devAddr_r;
   reg [1:0] lsMeta_r;
   reg [1:0] lsSync_r;
   reg suspMeta_r;
   reg suspSync_r;
   reg [1:0] lsFiltPrev_r;
   reg [31:0] rdata_nxt;
   wire [1:0] lsFilt;
   wire wrAcc;
   wire rdAcc;
   wire addrOk;
   wire tokAccept;
   wire isToken;
   wire resumeSe0;
   wire resumeK;
   wire wrSof;
   wire wrEpMatch;
   wire wrOtgMask;
   wire wrPwrSig;
   wire wrDevAddr;
   wire wrXcvr;
   wire se0Clr;
   wire kClr;

   function known;
      input [`ADDR_W-1:0] a;
      begin
         known = (a == `OFF_SOF) || (a == `OFF_PID) || (a == `OFF_EP) ||
            (a == `OFF_EPMATCH) || (a == `OFF_OTGMASK) || (a == `OFF_PWRSIG) ||
            (a == `OFF_XCVR) || (a == `OFF_DEVADDR);
      end
   endfunction

   function wsel;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] off;
      begin
         wsel = (a == off);
      end
   endfunction

   // Set wins over a clear in the same cycle, so a cause is never lost
   function causeNext;
      input cur;
      input setEv;
      input clrEv;
      begin
         if (setEv)
            causeNext = 1'b1;
         else if (clrEv)
            causeNext = 1'b0;
         else
            causeNext = cur;
      end
   endfunction

   // One wait state: a write lands on the edge that shows pready high
   assign wrAcc = psel && penable && pwrite && pready;
   assign rdAcc = psel && penable && !pwrite && !pready;
   assign isToken = (tokPid == `PID_TOKEN_OUT) || (tokPid == `PID_TOKEN_IN) ||
      (tokPid == `PID_TOKEN_SETUP);
   assign addrOk = (tokAddr == devAddr_r); // [RL15]
   assign tokAccept = tokValid && tokCheckOk && isToken && addrOk; // [RL15]

   // Per-register write strobes, shared by the writes and the flag clears
   assign wrSof = wrAcc && wsel(paddr, `OFF_SOF);
   assign wrEpMatch = wrAcc && wsel(paddr, `OFF_EPMATCH);
   assign wrOtgMask = wrAcc && wsel(paddr, `OFF_OTGMASK);
   assign wrPwrSig = wrAcc && wsel(paddr, `OFF_PWRSIG);
   assign wrDevAddr = wrAcc && wsel(paddr, `OFF_DEVADDR);
   assign wrXcvr = wrAcc && wsel(paddr, `OFF_XCVR);
   // Writing 1 to a cause bit keeps it; only a written 0 clears
   assign se0Clr = wrXcvr && !pwdata[`XCVR_SE0CAUSE_BIT]; // [RL10]
   assign kClr = wrXcvr && !pwdata[`XCVR_KCAUSE_BIT]; // [RL11]

   // Resume cause sampled on the filtered state entering SE0 or K while suspended and suspend control is on
   assign resumeSe0 = suspSync_r && suspCtl_r && (lsFilt == `LS_SE0) &&
      (lsFiltPrev_r != `LS_SE0);
   assign resumeK = suspSync_r && suspCtl_r && (lsFilt == `LS_K) &&
      (lsFiltPrev_r != `LS_K);

   // Pin inputs pass two flops before use
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lsMeta_r <= 2'h0;
         lsSync_r <= 2'h0;
         suspMeta_r <= 1'b0;
         suspSync_r <= 1'b0;
         lsFiltPrev_r <= 2'h0;
      end
      else
      begin
         lsMeta_r <= lineState;
         lsSync_r <= lsMeta_r;
         suspMeta_r <= suspended;
         suspSync_r <= suspMeta_r;
         lsFiltPrev_r <= lsFilt;
      end
   end

   linestate_filter #(.CNT_W(FILT_W)) uFilter
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .lineRaw(lsSync_r),
      .log2Delay(filt_r), // [RL12]
      .lineFilt(lsFilt)
   );

   // Register writes, token capture and cause flags
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sof_r <= 11'h000; // [RL1]
         pid_r <= 4'h0;
         endp_r <= 4'h0;
         endpValid_r <= 1'b0;
         epMatch_r <= 16'h0000;
         otgMask_r <= 32'h00000000;
         pwrData_r <= 8'h00;
         pwrValid_r <= 1'b0;
         pdDis_r <= 1'b0;
         se0Cause_r <= 1'b0;
         kCause_r <= 1'b0;
         filt_r <= 4'h0;
         suspCtl_r <= 1'b0;
         conf_r <= 3'h0;
         devAddr_r <= 7'h00;
      end
      else
      begin
         if (wrSof)
            sof_r <= pwdata[`SOF_HI:0]; // [RL1]
         if (wrEpMatch)
            epMatch_r <= pwdata[`EPM_HI:0]; // [RL5]
         if (wrOtgMask)
            otgMask_r <= pwdata; // [RL7]
         if (wrPwrSig)
         begin
            pwrData_r <= pwdata[`PWR_DATA_HI:0]; // [RL8]
            pwrValid_r <= pwdata[`PWR_VALID_BIT]; // [RL8]
         end
         if (wrDevAddr)
            devAddr_r <= pwdata[`DEVADDR_HI:0]; // [RL15]
         if (wrXcvr)
         begin
            pdDis_r <= pwdata[`XCVR_PDDIS_BIT]; // [RL9]
            filt_r <= pwdata[`XCVR_FILT_HI:`XCVR_FILT_LO]; // [RL12]
            suspCtl_r <= pwdata[`XCVR_SUSP_BIT]; // [RL13]
            conf_r <= pwdata[`XCVR_CONF_HI:`XCVR_CONF_LO]; // [RL14]
         end
         // Software may only clear the cause flags; a new cause wins over clear
         se0Cause_r <= causeNext(se0Cause_r, resumeSe0, se0Clr); // [RL10]
         kCause_r <= causeNext(kCause_r, resumeK, kClr); // [RL11]
         if (tokAccept)
         begin
            pid_r <= tokPid; // [RL2] [RL16]
            endp_r <= tokEndp; // [RL3] [RL16]
            endpValid_r <= 1'b1; // [RL4] [RL16]
         end
      end
   end

   // Read mux; reserved and unmapped bits read zero
   always @*
   begin
      rdata_nxt = 32'h00000000; // [RL17]
      case (paddr)
         `OFF_SOF: rdata_nxt[`SOF_HI:0] = sof_r; // [RL1]
         `OFF_PID: rdata_nxt[`PID_HI:0] = pid_r; // [RL2]
         `OFF_EP: rdata_nxt[`EP_VALID_BIT:0] = {endpValid_r, endp_r}; // [RL3] [RL4]
         `OFF_EPMATCH: rdata_nxt[`EPM_HI:0] = epMatch_r;
         `OFF_OTGMASK: rdata_nxt = otgMask_r;
         `OFF_PWRSIG: rdata_nxt[`PWR_VALID_BIT:0] = {pwrValid_r, pwrData_r};
         `OFF_DEVADDR: rdata_nxt[`DEVADDR_HI:0] = devAddr_r;
         `OFF_XCVR:
         begin
            rdata_nxt[`XCVR_PDDIS_BIT] = pdDis_r;
            rdata_nxt[`XCVR_SE0CAUSE_BIT] = se0Cause_r;
            rdata_nxt[`XCVR_KCAUSE_BIT] = kCause_r;
            rdata_nxt[`XCVR_FILT_HI:`XCVR_FILT_LO] = filt_r;
            rdata_nxt[`XCVR_SUSP_BIT] = suspCtl_r;
            rdata_nxt[`XCVR_CONF_HI:`XCVR_CONF_LO] = conf_r;
         end
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Bus answer and registered outputs
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         rxEndp <= 5'h00;
         rxEndpStrobe <= 1'b0;
         xcvrConf <= 3'h0;
         pulldownEn <= 1'b1;
         resumeReq <= 1'b0;
         lineFiltOut <= 2'h0;
         pwrData <= 8'h00;
         pwrValid <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !known(paddr);
         if (rdAcc)
            prdata <= rdata_nxt;
         rxEndpStrobe <= tokAccept;
         if (tokAccept)
         begin
            if (epMatch_r[tokEndp])
               rxEndp <= {1'b0, tokEndp} | `SPECIAL_EP_FLAG; // [RL6]
            else
               rxEndp <= {1'b0, tokEndp};
         end
         xcvrConf <= conf_r; // [RL14]
         pulldownEn <= !pdDis_r; // [RL9]
         resumeReq <= resumeSe0 || resumeK; // [RL13]
         lineFiltOut <= lsFilt; // [RL13]
         pwrData <= pwrData_r;
         pwrValid <= pwrValid_r;
      end
   end
endmodule // usb_token_status

//--- testbench/usb_far_model.sv
// Far-side model: decoded token feed and transceiver line pins
`timescale 1ns/1ps
module usb_far_model
(
   // Clock
   input wire sys_clk,
   // Token feed and line pins
   output logic tokValid = 1'b0,
   output logic [3:0] tokPid = 4'h0,
   output logic [6:0] tokAddr = 7'h00,
   output logic [3:0] tokEndp = 4'h0,
   output logic tokCheckOk = 1'b0,
   output logic [1:0] lineState = 2'h1,
   output logic suspended = 1'b0
);
   // Fields turn over once the strobe drops, so stale values never look valid
   task send(input [3:0] p, input [6:0] a, input [3:0] e, input ok);
      @(posedge sys_clk);
      {tokValid, tokPid, tokAddr, tokEndp, tokCheckOk} <= {1'b1, p, a, e, ok};
      @(posedge sys_clk);
      {tokValid, tokPid, tokAddr, tokEndp, tokCheckOk} <= {1'b0, ~p, ~a, ~e, ~ok};
   endtask
   task line(input [1:0] ls, input susp);
      @(posedge sys_clk);
      {lineState, suspended} <= {ls, susp};
   endtask
endmodule // usb_far_model

//--- testbench/usb_token_status_chk.sv
// Port assertions for the token status block
`timescale 1ns/1ps
`include "usb_token_status_defs.vh"
module usb_token_status_chk
#(
   parameter FILT_W = 16
)
(
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`ADDR_W-1:0] paddr,
   input wire pready,
   input wire pslverr,
   // Token feed and receive port
   input wire tokValid,
   input wire tokCheckOk,
   input wire [3:0] tokPid,
   input wire [3:0] tokEndp,
   input wire [4:0] rxEndp,
   input wire rxEndpStrobe,
   // Transceiver and power outputs
   input wire pulldownEn,
   input wire resumeReq,
   input wire [1:0] lineFiltOut,
   input wire [2:0] xcvrConf,
   input wire pwrValid,
   input wire [7:0] pwrData
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire acc = psel && penable && pwrite;
   wire wrPwr = acc && paddr == `OFF_PWRSIG;
   wire wrX = acc && paddr == `OFF_XCVR;
   a_strobe_cause: assert property (rxEndpStrobe |-> $past(tokValid && tokCheckOk))
      else $error("strobe without token");
   a_endp_copy: assert property (rxEndpStrobe |-> rxEndp[3:0] == $past(tokEndp))
      else $error("endpoint not copied");
   a_bad_check: assert property (tokValid && !tokCheckOk |=> !rxEndpStrobe)
      else $error("bad token accepted");
   a_sof_refused: assert property (tokValid && tokPid == `PID_TOKEN_SOF |=>
      !rxEndpStrobe) else $error("frame token accepted");
   a_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("no ready after one wait");
   a_err_unmapped: assert property (pready && psel && paddr > `OFF_XCVR |-> pslverr)
      else $error("unmapped without error");
   a_pwr_cause: assert property ($changed({pwrValid, pwrData}) |->
      $past(wrPwr) || $past(wrPwr, 2)) else $error("power word moved alone");
   a_conf_cause: assert property ($changed({xcvrConf, pulldownEn}) |->
      $past(wrX) || $past(wrX, 2)) else $error("control pins moved alone");
   a_resume_line: assert property (resumeReq |-> $changed(lineFiltOut) &&
      (lineFiltOut == `LS_SE0 || lineFiltOut == `LS_K)) else $error("resume without line change");
   c_special: cover property (rxEndpStrobe && rxEndp[4]);
   c_err: cover property (pslverr);
   c_resume: cover property (resumeReq);
endmodule // usb_token_status_chk

//--- testbench/testbench.sv
// Self-checking bench for the token status block
`timescale 1ns/1ps
`include "usb_token_status_defs.vh"
module testbench;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
   logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00, pwrData;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, tokValid, tokCheckOk, suspended, rxEndpStrobe;
   logic pulldownEn, resumeReq, pwrValid;
   logic [3:0] tokPid, tokEndp;
   logic [6:0] tokAddr;
   logic [1:0] lineState, lineFiltOut;
   logic [4:0] rxEndp;
   logic [2:0] xcvrConf;
   int bad_count = 0;
   int comparisons = 0;
   // Reserved and write-zero-clear bits are set on purpose in every row but the full-width OTGMASK one
   row_t rows [6] = '{'{`OFF_SOF, 32'hFFFFFFFF, 32'h7FF}, '{`OFF_EPMATCH, 32'hFFFF0020, 32'h20},
      '{`OFF_OTGMASK, 32'hA5A5F00F, 32'hA5A5F00F}, '{`OFF_PWRSIG, 32'hFFFFFFA5, 32'h1A5},
      '{`OFF_DEVADDR, 32'hFFFFFFAA, 32'h2A}, '{`OFF_XCVR, 32'hFFFFF2DF, 32'h402D0}};
   usb_token_status usb_token_status_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tokValid(tokValid), .tokPid(tokPid),
      .tokAddr(tokAddr), .tokEndp(tokEndp), .tokCheckOk(tokCheckOk), .lineState(lineState),
      .suspended(suspended), .rxEndp(rxEndp), .rxEndpStrobe(rxEndpStrobe), .xcvrConf(xcvrConf),
      .pulldownEn(pulldownEn), .resumeReq(resumeReq), .lineFiltOut(lineFiltOut),
      .pwrData(pwrData), .pwrValid(pwrValid));
   usb_far_model usb_far_model_inst (.sys_clk(sys_clk), .tokValid(tokValid), .tokPid(tokPid),
      .tokAddr(tokAddr), .tokEndp(tokEndp), .tokCheckOk(tokCheckOk), .lineState(lineState),
      .suspended(suspended));
   always #12.5 sys_clk = ~sys_clk;
   task test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until ready is seen high at an edge; the bench timeout ends a hang
   task apb(input [7:0] a, input wr, input [31:0] d);
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task tok(input [3:0] p, input [6:0] a, input [3:0] e, input ok, input [5:0] x);
      usb_far_model_inst.send(p, a, e, ok);
      #1;
      chk({rxEndpStrobe, rxEndp}, x);
   endtask
   // Resume pulses are counted over the whole wait, since they stand one cycle only
   task line_wait(input [1:0] ls, input susp, input [1:0] x, input int pulses);
      int seen;
      seen = 0;
      usb_far_model_inst.line(ls, susp);
      for (int k = 0; k < 30; k++)
      begin
         @(posedge sys_clk);
         seen += resumeReq;
         if (k == 3)
            chk(lineFiltOut, x);
      end
      chk(lineFiltOut, ls);
      chk(seen, pulses);
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      test_done;
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      chk(pulldownEn, 1'b1);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         apb(8'h28 + 8'(4 * i), 1'b0, 32'h0);
         chk({err, rd}, {1'b0, 32'h0});
      end
      apb(8'h44, 1'b0, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      foreach (rows[i])
      begin
         apb(rows[i].a, 1'b1, rows[i].w);
         apb(rows[i].a, 1'b0, 32'h0);
         chk(rd, rows[i].e);
      end
      chk({xcvrConf, pulldownEn, pwrValid, pwrData}, {3'h5, 2'b01, 8'hA5});
      tok(`PID_TOKEN_IN, 7'h2A, 4'h5, 1'b1, 6'h35);
      tok(`PID_TOKEN_OUT, 7'h2A, 4'h3, 1'b1, 6'h23);
      tok(`PID_TOKEN_SETUP, 7'h2B, 4'h7, 1'b1, 6'h03);
      tok(`PID_TOKEN_IN, 7'h2A, 4'h7, 1'b0, 6'h03);
      tok(`PID_TOKEN_SOF, 7'h2A, 4'h7, 1'b1, 6'h03);
      apb(`OFF_PID, 1'b1, 32'hFFFFFFFF);
      apb(`OFF_PID, 1'b0, 32'h0);
      chk(rd, `PID_TOKEN_OUT);
      apb(`OFF_EP, 1'b0, 32'h0);
      chk(rd, 32'h13);
      line_wait(2'h1, 1'b1, 2'h1, 0);
      line_wait(2'h0, 1'b1, 2'h1, 1);
      apb(`OFF_XCVR, 1'b0, 32'h0);
      chk(rd, 32'h422D0);
      apb(`OFF_XCVR, 1'b1, 32'h402D0);
      line_wait(2'h2, 1'b1, 2'h0, 1);
      apb(`OFF_XCVR, 1'b0, 32'h0);
      chk(rd, 32'h412D0);
      // Without the suspend controller no cause flag may appear
      apb(`OFF_XCVR, 1'b1, 32'h40250);
      line_wait(2'h0, 1'b1, 2'h2, 0);
      apb(`OFF_XCVR, 1'b0, 32'h0);
      chk(rd, 32'h40250);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      apb(`OFF_SOF, 1'b0, 32'h0);
      chk({pulldownEn, rd}, {1'b1, 32'h0});
      test_done;
   end
endmodule // testbench
bind usb_token_status usb_token_status_chk #(.FILT_W(FILT_W)) usb_token_status_chk_inst (
   .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .tokValid(tokValid), .tokCheckOk(tokCheckOk),
   .paddr(paddr), .tokPid(tokPid), .tokEndp(tokEndp), .rxEndp(rxEndp),
   .rxEndpStrobe(rxEndpStrobe), .pulldownEn(pulldownEn), .resumeReq(resumeReq),
   .lineFiltOut(lineFiltOut), .pwrValid(pwrValid), .xcvrConf(xcvrConf), .pwrData(pwrData));
